// ===== verilog/usdp_top.v
// shadow data port with receive/transmit path, apb slave and interrupt
// assumes apb master on clk, serial inputs asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "usdp_defs.vh"
module usdp_top
(
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire serialIn,
  input wire irSerialIn,
  output reg serialOut,
  output reg irSerialOutN,
  output wire irq
);
  // reload of BIT_CYC gives a bit of BIT_CYC+1 cycles; drift stays far below half a bit
  localparam integer BIT_CYC_I = `USDP_BIT_CYCLES;
  localparam integer HALF_CYC_I = `USDP_BIT_CYCLES / 2;
  localparam [15:0] BIT_CYC = BIT_CYC_I[15:0];
  localparam [15:0] HALF_CYC = HALF_CYC_I[15:0];
  localparam [2:0] RX_IDLE = 3'b001;
  localparam [2:0] RX_DATA = 3'b010;
  localparam [2:0] RX_STOP = 3'b100;
  localparam [1:0] TX_IDLE = 2'b01;
  localparam [1:0] TX_SHIFT = 2'b10;

  reg [1:0] ctrlQ;
  reg [2:0] maskQ;
  reg [2:0] irqStatQ;
  reg [7:0] rxBufQ;
  reg rxValidQ;
  reg [7:0] thrQ;
  reg thrFullQ;
  reg sinMetaQ;
  reg sinSyncQ;
  reg sirMetaQ;
  reg sirSyncQ;
  reg [2:0] rxStateQ;
  reg [15:0] rxCntQ;
  reg [2:0] rxBitQ;
  reg [7:0] rxShiftQ;
  reg [1:0] txStateQ;
  reg [15:0] txCntQ;
  reg [3:0] txBitQ;
  reg [9:0] txShiftQ;

  wire fifoEn = ctrlQ[`USDP_CTRL_FIFO_EN];
  wire irMode = ctrlQ[`USDP_CTRL_IR_MODE];
  wire apbDone = psel && penable;
  wire portHit = ((paddr & `USDP_PORT_MASK) == `USDP_PORT_BASE);
  wire portRd = apbDone && !pwrite && portHit;
  wire portWr = apbDone && pwrite && portHit;
  wire ctrlWr = apbDone && pwrite && (paddr == `USDP_CTRL_ADDR);
  wire maskWr = apbDone && pwrite && (paddr == `USDP_MASK_ADDR);
  wire irqRd = apbDone && !pwrite && (paddr == `USDP_IRQ_ADDR);
  wire known = portHit
    || (paddr == `USDP_CTRL_ADDR)
    || (paddr == `USDP_STAT_ADDR)
    || (paddr == `USDP_IRQ_ADDR)
    || (paddr == `USDP_MASK_ADDR);
  assign pready = 1'b1;
  // unmapped: write dropped, read gives zero, error flagged
  assign pslverr = apbDone && !known;

  // receive path
  // ir receive pin pulses high for a zero bit
  wire rxLine = irMode ? !sirSyncQ : sinSyncQ;
  reg rxDone;
  wire [7:0] rxFifoHead, txFifoHead;
  wire rxFifoFull, rxFifoEmpty, txFifoFull, txFifoEmpty;
  wire rxPush = rxDone && fifoEn && !rxFifoFull;
  wire rxPop = portRd && fifoEn;
  wire overrun = rxDone && (fifoEn ? rxFifoFull : rxValidQ);
  wire dataAvail = fifoEn ? !rxFifoEmpty : rxValidQ;
  // a full queue refuses the push inside the store
  wire txPush = portWr && fifoEn;
  reg txPop;
  wire thrEmpty = fifoEn ? txFifoEmpty : !thrFullQ;
  wire txAvail = fifoEn ? !txFifoEmpty : thrFullQ;
  wire [7:0] txByte = fifoEn ? txFifoHead : thrQ;
  reg thrEmptyPrevQ;

  usdp_fifo_mem rxFifo
  (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .flush(ctrlWr),
    .push(rxPush), .pushData(rxShiftQ), .pop(rxPop),
    .headData(rxFifoHead), .full(rxFifoFull), .empty(rxFifoEmpty), .count()
  );
  usdp_fifo_mem txFifo
  (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .flush(ctrlWr),
    .push(txPush), .pushData(pwdata[7:0]), .pop(txPop),
    .headData(txFifoHead), .full(txFifoFull), .empty(txFifoEmpty), .count()
  );

  // both serial pins are asynchronous to clk: two flops before any use
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sinMetaQ <= 1'b1;
      sinSyncQ <= 1'b1;
      sirMetaQ <= 1'b0;
      sirSyncQ <= 1'b0;
    end
    else if (clkEn)
    begin
      sinMetaQ <= serialIn;
      sinSyncQ <= sinMetaQ;
      sirMetaQ <= irSerialIn;
      sirSyncQ <= sirMetaQ;
    end
  end

  // receiver: start, 8 data bits lsb first, stop
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxStateQ <= RX_IDLE;
      rxCntQ <= 16'h0000;
      rxBitQ <= 3'h0;
      rxShiftQ <= 8'h00;
      rxDone <= 1'b0;
    end
    else if (clkEn)
    begin
      rxDone <= 1'b0;
      case (rxStateQ)
        RX_IDLE:
          // one and a half bits from the start edge lands mid data bit 0
          if (!rxLine)
          begin
            rxCntQ <= BIT_CYC + HALF_CYC;
            rxBitQ <= 3'h0;
            rxStateQ <= RX_DATA;
          end
        RX_DATA:
          if (rxCntQ == 16'h0000)
          begin
            rxShiftQ <= {rxLine, rxShiftQ[7:1]};
            rxCntQ <= BIT_CYC;
            rxBitQ <= rxBitQ + 3'h1;
            if (rxBitQ == 3'h7)
              rxStateQ <= RX_STOP;
          end
          else
            rxCntQ <= rxCntQ - 16'h0001;
        RX_STOP:
          if (rxCntQ == 16'h0000)
          begin
            rxDone <= 1'b1;
            rxStateQ <= RX_IDLE;
          end
          else
            rxCntQ <= rxCntQ - 16'h0001;
        default:
          rxStateQ <= RX_IDLE;
      endcase
    end
  end

  // single receive buffer, used with fifos off
  // a byte landing in the cycle of a read keeps the flag set
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxBufQ <= 8'h00;
      rxValidQ <= 1'b0;
    end
    else if (clkEn)
    begin
      if (rxDone && !fifoEn)
      begin
        rxBufQ <= rxShiftQ;
        rxValidQ <= 1'b1;
      end
      else if (portRd && !fifoEn)
        rxValidQ <= 1'b0;
    end
  end

  // transmit holding entry, used with fifos off
  // a write in the pop cycle keeps the flag: the new byte still waits
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      thrQ <= 8'h00;
      thrFullQ <= 1'b0;
    end
    else if (clkEn)
    begin
      if (portWr && !fifoEn)
      begin
        thrQ <= pwdata[7:0];
        thrFullQ <= 1'b1;
      end
      else if (txPop && !fifoEn)
        thrFullQ <= 1'b0;
    end
  end

  // transmitter; ir output is active low
  // the pop lands one cycle after the load, hence the idle guard on txPop
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      txStateQ <= TX_IDLE;
      txCntQ <= 16'h0000;
      txBitQ <= 4'h0;
      txShiftQ <= 10'h3ff;
      txPop <= 1'b0;
      serialOut <= 1'b1;
      irSerialOutN <= 1'b1;
    end
    else if (clkEn)
    begin
      txPop <= 1'b0;
      case (txStateQ)
        TX_IDLE:
          if (txAvail && !txPop)
          begin
            txShiftQ <= {1'b1, txByte, 1'b0};
            txPop <= 1'b1;
            txCntQ <= BIT_CYC;
            txBitQ <= 4'h0;
            txStateQ <= TX_SHIFT;
          end
        TX_SHIFT:
          if (txCntQ == 16'h0000)
          begin
            txShiftQ <= {1'b1, txShiftQ[9:1]};
            txCntQ <= BIT_CYC;
            txBitQ <= txBitQ + 4'h1;
            if (txBitQ == 4'h9)
              txStateQ <= TX_IDLE;
          end
          else
            txCntQ <= txCntQ - 16'h0001;
        default:
          txStateQ <= TX_IDLE;
      endcase
      serialOut <= irMode ? 1'b1 : txShiftQ[0];
      irSerialOutN <= irMode ? txShiftQ[0] : 1'b1;
    end
  end

  // control, mask, sticky events; event set beats read clear
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrlQ <= `USDP_CTRL_RESET;
      maskQ <= `USDP_MASK_RESET;
      irqStatQ <= 3'h0;
      thrEmptyPrevQ <= 1'b1;
    end
    else if (clkEn)
    begin
      if (ctrlWr)
        ctrlQ <= pwdata[1:0];
      if (maskWr)
        maskQ <= pwdata[2:0];
      thrEmptyPrevQ <= thrEmpty;
      irqStatQ <= (irqRd ? 3'h0 : irqStatQ)
        | {thrEmpty && !thrEmptyPrevQ, overrun, rxDone};
    end
  end
  assign irq = |(irqStatQ & maskQ);

  // read data loaded in the setup cycle, so the access phase needs no wait state
  always @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (clkEn && psel && !penable && !pwrite)
    begin
      if (portHit)
        prdata <= {24'h000000, fifoEn ? rxFifoHead : rxBufQ};
      else if (paddr == `USDP_CTRL_ADDR)
        prdata <= {30'h0, ctrlQ};
      else if (paddr == `USDP_STAT_ADDR)
        prdata <= {26'h0, thrEmpty, 4'h0, dataAvail};
      else if (paddr == `USDP_IRQ_ADDR)
        prdata <= {29'h0, irqStatQ};
      else if (paddr == `USDP_MASK_ADDR)
        prdata <= {29'h0, maskQ};
      else
        prdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/usdp_defs.vh
// constants for the shadow receive/transmit data port block
// assumes inclusion by bare name from design files under verilog/
// What this block does
// - sixteen consecutive word addresses all alias the same data port
// - fifos off: port read returns last received byte, valid only while data-available flag set
// - fifos off: new byte overwrites unread buffer and flags overrun
// - fifos on: port read returns and pops oldest receive fifo entry
// - receive fifo full: keep stored bytes, drop new one, flag overrun
// - fifos off: one write clears transmit-holding-empty flag
// - fifos off: second write before empty replaces pending byte
// - fifos on: sixteen writes accepted before transmit fifo full
// - write while transmit fifo full is dropped, queue untouched
// - receive from serial or infrared input by mode, transmit on matching output
`ifndef USDP_DEFS_VH
`define USDP_DEFS_VH
`define USDP_PORT_BASE 12'h000
`define USDP_PORT_MASK 12'hfc0
`define USDP_PORT_LAST 12'h03c
`define USDP_CTRL_ADDR 12'h040
`define USDP_STAT_ADDR 12'h044
`define USDP_IRQ_ADDR 12'h048
`define USDP_MASK_ADDR 12'h04c
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_DATA_AVAIL 0
`define USDP_STAT_THR_EMPTY 5
`define USDP_IRQ_RX 0
`define USDP_IRQ_OVERRUN 1
`define USDP_IRQ_TX_EMPTY 2
`define USDP_CTRL_RESET 2'h0
`define USDP_MASK_RESET 3'h0
`define USDP_FIFO_DEPTH 16
`define USDP_PTR_W 4
`define USDP_BIT_TIME_NS 8680
`define USDP_CLK_NS 10
`define USDP_BIT_CYCLES (`USDP_BIT_TIME_NS / `USDP_CLK_NS)
`endif

// ===== verilog/usdp_fifo_mem.v
// small byte fifo store, registered read data
// assumes one clock, synchronous active-high reset; push/pop guarded here against full/empty
`timescale 1ns/100ps
`default_nettype none
`include "usdp_defs.vh"
module usdp_fifo_mem
(
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire flush,
  input wire push,
  input wire [7:0] pushData,
  input wire pop,
  output reg [7:0] headData,
  output wire full,
  output wire empty,
  output wire [4:0] count
);
  reg [7:0] memQ [0:`USDP_FIFO_DEPTH-1];
  reg [3:0] wrPtrQ;
  reg [3:0] rdPtrQ;
  reg [4:0] cntQ;
  wire doPush;
  wire doPop;
  wire [3:0] rdNext;
  assign full = (cntQ == 5'd16);
  assign empty = (cntQ == 5'd0);
  assign count = cntQ;
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign rdNext = doPop ? rdPtrQ + 4'h1 : rdPtrQ;
  always @(posedge clk)
  begin
    if (sys_rst || (clkEn && flush))
    begin
      wrPtrQ <= 4'h0;
      rdPtrQ <= 4'h0;
      cntQ <= 5'h00;
      headData <= 8'h00;
    end
    else if (clkEn)
    begin
      if (doPush)
      begin
        memQ[wrPtrQ] <= pushData;
        wrPtrQ <= wrPtrQ + 4'h1;
      end
      rdPtrQ <= rdNext;
      cntQ <= cntQ + {4'h0, doPush} - {4'h0, doPop};
      // head register follows pointer; write-through when landing in an empty slot
      // held once empty, so no unwritten slot ever shows on the head
      if (doPush && (wrPtrQ == rdNext))
        headData <= pushData;
      else if (cntQ != {4'h0, doPop})
        headData <= memQ[rdNext];
    end
  end
endmodule
`default_nettype wire

// ===== sim/usdp_checker.sv
// port-level assertions for the shadow data port top
// assumes binding onto usdp_top, one clock, sync active-high reset
`timescale 1ns/100ps
`default_nettype none
module usdp_checker
(
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire serialOut,
  input wire irSerialOutN,
  input wire irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence sAccess;
    psel && penable;
  endsequence
  sequence sPortRead;
    sAccess ##0 !pwrite && paddr <= 12'h03c;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (sAccess ##0 paddr >= 12'h050 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (sAccess ##0 paddr < 12'h050 |-> !pslverr)
    else $error("mapped access flagged");
  a_port_upper: assert property (sPortRead |-> prdata[31:8] == 24'h0)
    else $error("port read upper bits set");
  a_unmapped_zero: assert property (sAccess ##0 !pwrite && paddr >= 12'h050 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // reset itself is the cause here, so the default disable is lifted
  a_reset_idle: assert property (disable iff (1'b0) sys_rst && clkEn |=> serialOut && irSerialOutN && !irq && prdata == 32'h0)
    else $error("outputs not idle after reset");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
  a_start_bit: assert property ($fell(serialOut) |=> !serialOut [*8])
    else $error("start bit too short");
  a_one_output: assert property (serialOut || irSerialOutN)
    else $error("both serial outputs active");
endmodule
bind usdp_top usdp_checker u_chk (.clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .pslverr, .serialOut, .irSerialOutN, .irq);
`default_nettype wire

// ===== sim/usdp_remote_uart.sv
// remote serial end: sends 8N1 bytes in, decodes bytes sent out on txLine, counts ir pulses on irTxLineN
// assumes the bit time of usdp_defs.vh and the bench clock
`timescale 1ns/100ps
`default_nettype none
`include "usdp_defs.vh"
module usdp_remote_uart
(
  input wire clk,
  output logic rxLine,
  output logic irRxLine,
  input wire txLine,
  input wire irTxLineN,
  output logic [7:0] gotByte,
  output var int nGot,
  output var int nIrPulse
);
  localparam int BC = `USDP_BIT_CYCLES;
  initial
  begin
    rxLine = 1'b1;
    irRxLine = 1'b0;
    gotByte = 8'h0;
    nGot = 0;
    nIrPulse = 0;
  end
  task automatic sendByte(input logic [7:0] b, input logic ir);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      if (ir)
        irRxLine <= !frame[i];
      else
        rxLine <= frame[i];
      repeat (BC) @(posedge clk);
    end
  endtask
  // sample mid-bit so edge jitter of the sender cannot matter
  always @(negedge txLine)
  begin
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BC) @(posedge clk);
      gotByte[i] = txLine;
    end
    nGot++;
  end
  always @(negedge irTxLineN) nIrPulse++;
endmodule
`default_nettype wire

// ===== sim/test_uart_shadow_rx_tx_data_port.sv
// self-checking bench for usdp_top over apb with a remote serial end
// assumes the register map of usdp_defs.vh and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "usdp_defs.vh"
module test_uart_shadow_rx_tx_data_port;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;
  wire pready;
  wire [31:0] prdata;
  wire pslverr;
  wire serialIn;
  wire irSerialIn;
  wire serialOut;
  wire irSerialOutN;
  wire irq;
  wire [7:0] gotByte;
  int nGot;
  int nIrPulse;
  int n_fail = 0;
  int comparisons = 0;
  int g0;
  int p0;
  always #5 clk = ~clk;
  usdp_top dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .serialIn(serialIn), .irSerialIn(irSerialIn), .serialOut(serialOut),
    .irSerialOutN(irSerialOutN), .irq(irq));
  usdp_remote_uart far (.clk(clk), .rxLine(serialIn), .irRxLine(irSerialIn), .txLine(serialOut),
    .irTxLineN(irSerialOutN), .gotByte(gotByte), .nGot(nGot), .nIrPulse(nIrPulse));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h044, 32'h0);
    chk(rd & 32'h21, 32'h20);
    apb(1'b0, 12'h050, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h04c, 32'h1);
    far.sendByte(8'ha5, 1'b0);
    far.sendByte(8'h3c, 1'b0);
    repeat (20) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h048, 32'h0);
    chk(rd & 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 12'h03c, 32'h0);
    chk(rd, 32'h3c);
    apb(1'b0, 12'h044, 32'h0);
    chk(rd & 32'h21, 32'h20);
    // third write lands while the second still waits, so it replaces it
    apb(1'b1, 12'h004, 32'h11);
    apb(1'b1, 12'h008, 32'h22);
    apb(1'b1, 12'h00c, 32'hab33);
    apb(1'b0, 12'h044, 32'h0);
    chk(rd & 32'h20, 32'h0);
    repeat (21 * `USDP_BIT_CYCLES) @(posedge clk);
    chk({24'h0, gotByte}, 32'h33);
    chk(nGot, 32'h2);
    apb(1'b1, 12'h040, 32'h1);
    far.sendByte(8'h5a, 1'b0);
    far.sendByte(8'hc3, 1'b0);
    repeat (20) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'hc3);
    apb(1'b1, 12'h040, 32'h3);
    g0 = nGot;
    p0 = nIrPulse;
    apb(1'b1, 12'h000, 32'h0);
    far.sendByte(8'h96, 1'b1);
    repeat (40) @(posedge clk);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h96);
    chk(nGot - g0, 32'h0);
    chk(nIrPulse > p0, 32'h1);
    // fill past the depth; the run ends before the queue drains
    for (int i = 0; i < 18; i++) apb(1'b1, 12'h000, i);
    apb(1'b0, 12'h044, 32'h0);
    chk(rd & 32'h20, 32'h0);
    give_verdict;
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    n_fail++;
    give_verdict;
  end
endmodule
`default_nettype wire
